// File: rtl/css_pkg.sv
// Package for the clock source switch and fail-safe monitor block.
// Assumes a 125 MHz bus clock and AXI4-Lite software access with 32-bit data.
package css_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] CSS_OFS_CTRL = 8'h00;
   localparam logic [7:0] CSS_OFS_TRIM = 8'h04;
   localparam logic [7:0] CSS_OFS_STAT = 8'h08;

   // Control register field positions.
   localparam int CSS_CUR_LSB = 12;
   localparam int CSS_REQ_LSB = 8;
   localparam int CSS_LOCK_BIT = 5;
   localparam int CSS_FAIL_BIT = 3;
   localparam int CSS_SWREQ_BIT = 0;

   // Status register field positions.
   localparam int CSS_ST_INTERNAL_LOW_POWER_RC_BIT = 0;
   localparam int CSS_ST_MULT_LSB = 1;
   localparam int CSS_ST_SWEN_BIT = 3;
   localparam int CSS_ST_MONEN_BIT = 4;
   localparam int CSS_ST_BUSY_BIT = 5;
   localparam int CSS_ST_SEL_LSB = 8;

   // ************************************************************
   // Encodings and reset values
   // ************************************************************
   localparam logic [2:0] CSS_GRP_SEC = 3'h0;
   localparam logic [2:0] CSS_GRP_FRC = 3'h1;
   localparam logic [2:0] CSS_GRP_INTERNAL_LOW_POWER_RC = 3'h2;
   localparam logic [2:0] CSS_GRP_PRI = 3'h3;
   localparam logic [2:0] CSS_GRP_PLL = 3'h7;

   localparam logic [1:0] CSS_MULT_NONE = 2'h0;
   localparam logic [1:0] CSS_MULT_X4 = 2'h1;
   localparam logic [1:0] CSS_MULT_X8 = 2'h2;
   localparam logic [1:0] CSS_MULT_X16 = 2'h3;

   localparam logic [3:0] CSS_TRIM_RST = 4'h0;
   localparam logic [1:0] CSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSS_RESP_SLVERR = 2'h2;

   // Low-power RC periods without a system clock edge before failure.
   localparam logic [3:0] CSS_FAIL_TICKS = 4'h4;

   typedef enum logic [1:0] {
      CSS_ST_IDLE = 2'b00,
      CSS_ST_WAIT = 2'b01,
      CSS_ST_DONE = 2'b11
   } css_state_e;

   // Configuration fuses, sampled once after reset.
   typedef struct packed {
      logic [1:0] switch_monitor_config;
      logic [2:0] reset_group_config;
      logic [4:0] primary_option_config;
      logic watchdog_config;
   } css_cfg_s;

   // Steering towards the oscillator sources.
   typedef struct packed {
      logic [2:0] group_select;
      logic [1:0] pll_multiplier;
      logic pll_enable;
      logic [3:0] fast_rc_trim;
      logic internal_low_power_rc_enable;
   } css_osc_s;

endpackage

// File: rtl/css_clock_switch.sv
// Clock source control: group switching, fail-safe monitor, PLL and RC control.
// Assumes all oscillator status inputs are synchronous pulses or levels on aclk.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - PLL gain selectable as four, eight or sixteen.
// - Lock status follows PLL lock, readable as a read-only bit.
// - Current group 001 runs the system from the fast RC.
// - Four-bit signed trim offsets fast RC in 1.5 percent steps.
// - PLL group uses multiplier from primary option codes 00101, 00110, 00111.
// - Low-power RC clocks power-up timer, watchdog and monitor.
// - Low-power RC on at reset; after timer, kept only if needed.
// - Monitor enabled keeps low-power RC on except in Sleep.
// - Oscillator failure raises trap and moves clock to fast RC.
// - Failure loads fast RC group, sets fail flag, clears switch request.
// - Failure leaves watchdog running on the low-power RC.
// - Timer expiry before slow oscillator starts counts as failure.
// - Switching only between the five groups; primary option from configuration.
// - Current group read-only; software writes requested group separately.
// - Reset loads current and requested group from configuration.
// - Switch request set starts a switch; clearing it aborts.
// - Switch-monitor configuration 1x disables switching and monitor.
// - Switching disabled: configuration selects clock, current group only reports.
// - Group codes: 111 PLL, 011 primary, 010 INTERNAL_LOW_POWER_RC, 001 INTERNAL_FAST_RC, 000 secondary.
// - Configuration 01 enables switching only; 00 enables switching and monitor.
// - Lock reads zero unless PLL selected; clears when switch starts.
module css_clock_switch (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire css_pkg::css_cfg_s cfg_in,
   input wire logic pll_locked,
   input wire logic sys_clk_edge,
   input wire logic internal_low_power_rc_tick,
   input wire logic power_up_timer_expired,
   input wire logic slow_osc_started,
   input wire logic sleep_mode,
   input wire logic soft_watchdog_enable,
   input wire logic switch_done,
   output css_pkg::css_osc_s osc_ctrl,
   output logic clock_fail_trap
);

   // ************************************************************
   // State
   // ************************************************************
   css_pkg::css_cfg_s cfg_reg;
   logic cfg_loaded_reg;
   logic [2:0] current_clock_group_reg, current_clock_group_next;
   logic [2:0] requested_clock_group_reg, requested_clock_group_next;
   logic switch_request_bit_reg, switch_request_bit_next;
   logic clock_fail_flag_reg, clock_fail_flag_next;
   logic lock_reg, lock_next;
   logic [3:0] fast_rc_trim_reg;
   logic [3:0] miss_cnt_reg, miss_cnt_next;
   logic timer_seen_reg;
   css_pkg::css_state_e state_reg, state_next;
   css_pkg::css_osc_s osc_next;
   logic trap_next;

   // ************************************************************
   // Bus slave state
   // ************************************************************
   logic aw_held_reg, w_held_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // ************************************************************
   // Decoding
   // ************************************************************
   // Switch-monitor configuration: bit 1 set disables both functions.
   // Default disables all
   wire switching_enabled = cfg_loaded_reg & ~cfg_reg.switch_monitor_config[1];
   wire monitor_enabled = switching_enabled & ~cfg_reg.switch_monitor_config[0];

   // A write lands at the edge at which address and data are both present.
   wire aw_ok = s_axi_awvalid & s_axi_awready;
   wire w_ok = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_held_reg | aw_ok;
   wire w_have = w_held_reg | w_ok;
   wire [7:0] wr_addr = aw_held_reg ? waddr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
   wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
   wire wr_ctrl = wr_fire & (wr_addr == css_pkg::CSS_OFS_CTRL);
   wire wr_trim = wr_fire & (wr_addr == css_pkg::CSS_OFS_TRIM) & wr_strb[0];
   wire wr_map = (wr_addr == css_pkg::CSS_OFS_CTRL) | (wr_addr == css_pkg::CSS_OFS_TRIM)
      | (wr_addr == css_pkg::CSS_OFS_STAT);
   wire wr_lo = wr_ctrl & wr_strb[0];
   wire wr_hi = wr_ctrl & wr_strb[1];
   wire rd_fire = s_axi_arvalid & s_axi_arready;

   wire [2:0] req_written = wr_data[css_pkg::CSS_REQ_LSB +: 3];
   wire sw_set = wr_lo & wr_data[css_pkg::CSS_SWREQ_BIT] & ~switch_request_bit_reg;
   wire sw_clear = wr_lo & ~wr_data[css_pkg::CSS_SWREQ_BIT];
   wire [2:0] target_group = wr_hi ? req_written : requested_clock_group_reg;
   wire valid_group = (target_group == css_pkg::CSS_GRP_SEC)
      | (target_group == css_pkg::CSS_GRP_FRC) | (target_group == css_pkg::CSS_GRP_INTERNAL_LOW_POWER_RC)
      | (target_group == css_pkg::CSS_GRP_PRI) | (target_group == css_pkg::CSS_GRP_PLL);
   wire switch_start = sw_set & switching_enabled & valid_group & (state_reg == css_pkg::CSS_ST_IDLE)
      & (target_group != current_clock_group_reg);
   wire switch_redundant = sw_set & switching_enabled & valid_group
      & (state_reg == css_pkg::CSS_ST_IDLE) & (target_group == current_clock_group_reg);

   // Both failure sources count only while the monitor is enabled.
   // Missing edge detection
   wire miss_fail = monitor_enabled & ~sleep_mode & internal_low_power_rc_tick
      & (miss_cnt_reg == css_pkg::CSS_FAIL_TICKS - 4'h1) & ~sys_clk_edge;
   wire start_fail = monitor_enabled & power_up_timer_expired & ~timer_seen_reg & ~slow_osc_started;
   wire clock_failure = miss_fail | start_fail;

   // With switching disabled the fuses steer the clock; writes only set the requested group.
   // Configuration steers directly
   wire [2:0] effective_group = switching_enabled ? current_clock_group_reg
      : cfg_reg.reset_group_config;

   wire [1:0] mult_sel = cfg_reg.primary_option_config[1:0];
   wire pll_selected = effective_group == css_pkg::CSS_GRP_PLL;

   // Software and configuration watchdog enables both keep the low-power RC alive.
   wire watchdog_on = cfg_reg.watchdog_config | soft_watchdog_enable;
   wire internal_low_power_rc_needed = (monitor_enabled & ~sleep_mode) | watchdog_on
      | (effective_group == css_pkg::CSS_GRP_INTERNAL_LOW_POWER_RC);

   // ************************************************************
   // Switch sequencer and control bits
   // ************************************************************
   // Later statements take priority: abort, then failure, then fixed selection.
   // A request for an undefined group stays pending until software or a failure clears it.
   always_comb begin
      state_next = state_reg;
      current_clock_group_next = current_clock_group_reg;
      requested_clock_group_next = requested_clock_group_reg;
      switch_request_bit_next = switch_request_bit_reg;
      clock_fail_flag_next = clock_fail_flag_reg;
      trap_next = 1'b0;

      if (wr_hi) begin
         requested_clock_group_next = req_written;
      end

      if (sw_set & switching_enabled) begin
         switch_request_bit_next = 1'b1;
      end

      if (switch_start) begin
         // A valid switch clears the fail flag.
         clock_fail_flag_next = 1'b0;
         state_next = css_pkg::CSS_ST_WAIT;
      end

      if (switch_redundant) begin
         switch_request_bit_next = 1'b0;
      end

      // The fail flag is cleared by writing zero; a fresh failure wins below.
      if (wr_lo & ~wr_data[css_pkg::CSS_FAIL_BIT]) begin
         clock_fail_flag_next = 1'b0;
      end

      case (state_reg)
         css_pkg::CSS_ST_IDLE: begin
         end
         css_pkg::CSS_ST_WAIT: begin
            if (sw_clear) begin
               state_next = css_pkg::CSS_ST_IDLE;
            end else if (switch_done) begin
               state_next = css_pkg::CSS_ST_DONE;
            end
         end
         css_pkg::CSS_ST_DONE: begin
            current_clock_group_next = requested_clock_group_reg;
            switch_request_bit_next = 1'b0;
            state_next = css_pkg::CSS_ST_IDLE;
         end
         default: begin
            state_next = css_pkg::CSS_ST_IDLE;
         end
      endcase

      if (sw_clear) begin
         switch_request_bit_next = 1'b0;
      end

      if (clock_failure) begin
         current_clock_group_next = css_pkg::CSS_GRP_FRC;
         clock_fail_flag_next = 1'b1;
         switch_request_bit_next = 1'b0;
         state_next = css_pkg::CSS_ST_IDLE;
         trap_next = 1'b1;
      end

      if (!switching_enabled) begin
         current_clock_group_next = cfg_reg.reset_group_config;
      end
   end

   // Counts low-power RC periods without a system clock edge; Sleep holds it at zero.
   // A detected failure restarts the count, so a lasting loss raises a trap every four periods.
   always_comb begin
      miss_cnt_next = miss_cnt_reg;
      if (sys_clk_edge | ~monitor_enabled | sleep_mode | miss_fail) begin
         miss_cnt_next = 4'h0;
      end else if (internal_low_power_rc_tick) begin
         miss_cnt_next = miss_cnt_reg + 4'h1;
      end
   end

   // Lock stays low while a switch is pending, so a stale lock is never shown.
   // Lock follows loop
   assign lock_next = pll_locked & pll_selected & ~switch_start & (state_reg == css_pkg::CSS_ST_IDLE);

   // Steering is registered and follows the group state one cycle later.
   always_comb begin
      osc_next = '0;
      osc_next.group_select = effective_group;
      osc_next.pll_enable = pll_selected;
      osc_next.pll_multiplier = pll_selected ? mult_sel : css_pkg::CSS_MULT_NONE;
      osc_next.fast_rc_trim = fast_rc_trim_reg;
      osc_next.internal_low_power_rc_enable = ~timer_seen_reg | internal_low_power_rc_needed;
   end

   // Configuration is captured once, at the first edge after reset, then held.
   // The low-power RC starts at that edge because it times the power-up delay.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= '0;
         cfg_loaded_reg <= 1'b0;
         current_clock_group_reg <= css_pkg::CSS_GRP_FRC;
         requested_clock_group_reg <= css_pkg::CSS_GRP_FRC;
         switch_request_bit_reg <= 1'b0;
         clock_fail_flag_reg <= 1'b0;
         lock_reg <= 1'b0;
         fast_rc_trim_reg <= css_pkg::CSS_TRIM_RST;
         miss_cnt_reg <= 4'h0;
         timer_seen_reg <= 1'b0;
         state_reg <= css_pkg::CSS_ST_IDLE;
         osc_ctrl <= '0;
         clock_fail_trap <= 1'b0;
      end else if (!cfg_loaded_reg) begin
         cfg_reg <= cfg_in;
         cfg_loaded_reg <= 1'b1;
         current_clock_group_reg <= cfg_in.reset_group_config;
         requested_clock_group_reg <= cfg_in.reset_group_config;
         osc_ctrl.internal_low_power_rc_enable <= 1'b1;
      end else begin
         current_clock_group_reg <= current_clock_group_next;
         requested_clock_group_reg <= requested_clock_group_next;
         switch_request_bit_reg <= switch_request_bit_next;
         clock_fail_flag_reg <= clock_fail_flag_next;
         lock_reg <= lock_next;
         if (wr_trim) begin
            fast_rc_trim_reg <= wr_data[3:0];
         end
         miss_cnt_reg <= miss_cnt_next;
         timer_seen_reg <= timer_seen_reg | power_up_timer_expired;
         state_reg <= state_next;
         osc_ctrl <= osc_next;
         clock_fail_trap <= trap_next;
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   // Unused register bits read as zero.
   wire [31:0] ctrl_word = {17'h00000, current_clock_group_reg, 1'b0, requested_clock_group_reg,
      2'h0, lock_reg, 1'b0, clock_fail_flag_reg, 2'h0, switch_request_bit_reg};
   wire [31:0] trim_word = {28'h0000000, fast_rc_trim_reg};
   wire [31:0] stat_word = {21'h000000, osc_ctrl.group_select, 2'h0,
      state_reg != css_pkg::CSS_ST_IDLE, monitor_enabled, switching_enabled,
      osc_ctrl.pll_multiplier, osc_ctrl.internal_low_power_rc_enable};
   wire rd_ctrl = s_axi_araddr == css_pkg::CSS_OFS_CTRL;
   wire rd_trim = s_axi_araddr == css_pkg::CSS_OFS_TRIM;
   wire rd_stat = s_axi_araddr == css_pkg::CSS_OFS_STAT;
   wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_trim ? trim_word : rd_stat ? stat_word : 32'h0;
   wire rd_map = rd_ctrl | rd_trim | rd_stat;

   // Address and data are taken in either order and held until both are here.
   // A pending response closes both channels until the master accepts it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= css_pkg::CSS_RESP_OKAY;
      end else begin
         if (aw_ok) begin
            waddr_reg <= s_axi_awaddr;
         end
         if (w_ok) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         aw_held_reg <= aw_have & ~wr_fire;
         w_held_reg <= w_have & ~wr_fire;
         s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~wr_fire & cfg_loaded_reg;
         s_axi_wready <= ~w_have & ~s_axi_bvalid & ~wr_fire & cfg_loaded_reg;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? css_pkg::CSS_RESP_OKAY : css_pkg::CSS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data are captured at the address handshake and held until accepted.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= css_pkg::CSS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_fire & cfg_loaded_reg;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_map ? css_pkg::CSS_RESP_OKAY : css_pkg::CSS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// File: testbench/css_switch_properties.sv
// Concurrent checks on the ports of the clock source switch block.
// Assumes cfg_in is changed only while aresetn is low.
`timescale 1ns/10ps
`default_nettype none
module css_switch_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire css_pkg::css_cfg_s cfg_in,
   input wire logic pll_locked,
   input wire logic power_up_timer_expired,
   input wire logic sleep_mode,
   input wire css_pkg::css_osc_s osc_ctrl,
   input wire logic clock_fail_trap
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ************************************************************
   // Fail-safe and selection checks
   // ************************************************************
   a_trap_one_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
      else $error("clock fail trap longer than one cycle");
   a_trap_to_frc: assert property (clock_fail_trap |-> ##[0:1]
      osc_ctrl.group_select == css_pkg::CSS_GRP_FRC)
      else $error("failure did not select the fast RC");
   a_trap_keeps_internal_low_power_rc: assert property (clock_fail_trap && !sleep_mode |->
      ##[0:1] osc_ctrl.internal_low_power_rc_enable) else $error("low-power RC stopped on failure");
   a_trap_needs_monitor: assert property (clock_fail_trap |->
      cfg_in.switch_monitor_config == 2'h0) else $error("trap with monitor disabled");
   a_lock_reads_zero: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == css_pkg::CSS_OFS_CTRL && !pll_locked && !$past(pll_locked)
      |=> s_axi_rdata[css_pkg::CSS_LOCK_BIT] == 1'b0) else $error("lock read high");
   a_mult_from_cfg: assert property (osc_ctrl.group_select == css_pkg::CSS_GRP_PLL
      && cfg_in.primary_option_config inside {5'h05, 5'h06, 5'h07} |->
      osc_ctrl.pll_multiplier == cfg_in.primary_option_config[1:0])
      else $error("loop multiplier differs from configuration");
   a_fixed_select: assert property (cfg_in.switch_monitor_config[1] && $past(aresetn)
      && $past(aresetn, 2) && $past(aresetn, 3) |->
      osc_ctrl.group_select == cfg_in.reset_group_config)
      else $error("selection moved with switching disabled");
   a_internal_low_power_rc_before_timer: assert property ($past(aresetn) && !power_up_timer_expired
      && !$past(power_up_timer_expired) |-> osc_ctrl.internal_low_power_rc_enable)
      else $error("low-power RC off before timer expiry");
endmodule

bind css_clock_switch css_switch_props u_props (.aclk, .aresetn, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .cfg_in, .pll_locked,
   .power_up_timer_expired, .sleep_mode, .osc_ctrl, .clock_fail_trap);
`default_nettype wire

// File: testbench/css_osc_model.sv
// Model of the oscillator sources seen by the clock source switch block.
// Assumes all status it returns is synchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
module css_osc_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire css_pkg::css_osc_s osc_ctrl,
   input wire logic halt_clk,
   input wire logic lock_ok,
   input wire logic done_en,
   output logic sys_clk_edge,
   output logic internal_low_power_rc_tick,
   output logic pll_locked,
   output logic switch_done
);
   logic [2:0] tick_reg;
   logic lock_reg;
   logic done_reg;
   assign internal_low_power_rc_tick = (tick_reg == 3'h7) & osc_ctrl.internal_low_power_rc_enable;
   assign sys_clk_edge = ~halt_clk;
   assign pll_locked = lock_reg;
   assign switch_done = done_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_reg <= 3'h0;
         lock_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         tick_reg <= tick_reg + 3'h1;
         lock_reg <= osc_ctrl.pll_enable & lock_ok;
         done_reg <= done_en & (tick_reg[1:0] == 2'h3);
      end
   end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the clock source switch block over AXI4-Lite.
// Assumes the oscillator model answers switches every fourth cycle.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   css_pkg::css_cfg_s cfg = 11'h000;
   css_pkg::css_osc_s osc;
   logic expired = 1'b0, slow_ok = 1'b1, sleep = 1'b0, soft_wd = 1'b0;
   logic halt = 1'b0, lock_ok = 1'b0, done_en = 1'b0;
   logic sys_edge, tick, locked, sw_done, trap;
   logic [2:0] grps [4] = '{3'h3, 3'h7, 3'h2, 3'h2};
   int num_errors = 0, tests_run = 0, cyc = 0;

   always #4 aclk = ~aclk;

   css_clock_switch dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cfg_in(cfg), .pll_locked(locked), .sys_clk_edge(sys_edge),
      .internal_low_power_rc_tick(tick), .power_up_timer_expired(expired), .slow_osc_started(slow_ok),
      .sleep_mode(sleep), .soft_watchdog_enable(soft_wd), .switch_done(sw_done),
      .osc_ctrl(osc), .clock_fail_trap(trap));
   css_osc_model osc_model (.aclk(aclk), .aresetn(aresetn), .osc_ctrl(osc),
      .halt_clk(halt), .lock_ok(lock_ok), .done_en(done_en), .sys_clk_edge(sys_edge),
      .internal_low_power_rc_tick(tick), .pll_locked(locked), .switch_done(sw_done));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdt(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rdt(a);
      chk(rd & m, e);
   endtask

   task automatic sw(input logic [2:0] g);
      wr(css_pkg::CSS_OFS_CTRL, {21'h0, g, 8'h01});
      do begin
         rdt(css_pkg::CSS_OFS_CTRL);
      end while (rd[0] !== 1'b0);
   endtask

   task automatic wait_trap();
      int n;
      n = 0;
      while (trap !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      chk({31'h0, trap}, 32'h1);
   endtask

   task automatic rst(input css_pkg::css_cfg_s c);
      @(posedge aclk);
      aresetn <= 1'b0;
      cfg <= c;
      expired <= 1'b0;
      halt <= 1'b0;
      sleep <= 1'b0;
      soft_wd <= 1'b0;
      slow_ok <= 1'b1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask

   function automatic css_pkg::css_cfg_s mk(input logic [1:0] m, input logic [2:0] g,
                                            input logic [4:0] p);
      mk = {m, g, p, 1'b0};
   endfunction

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      rst(mk(2'h0, 3'h1, 5'h07));
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7700, 32'h1100);
      chk(osc.group_select, css_pkg::CSS_GRP_FRC);
      rdc(css_pkg::CSS_OFS_STAT, 32'h18, 32'h18);
      // The trim sweep ends on a negative code, below the x16 limit.
      for (int i = 0; i < 16; i++) begin
         wr(css_pkg::CSS_OFS_TRIM, 32'(i));
         rdc(css_pkg::CSS_OFS_TRIM, 32'hF, 32'(i));
         chk(osc.fast_rc_trim, 32'(i));
      end
      wr(css_pkg::CSS_OFS_CTRL, 32'h7200);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7701, 32'h1200);
      wr(8'h0C, 32'h1);
      chk(resp, css_pkg::CSS_RESP_SLVERR);
      rdc(8'h0C, 32'hFFFFFFFF, 32'h0);
      chk(resp, css_pkg::CSS_RESP_SLVERR);
      done_en <= 1'b1;
      for (int k = 5; k < 8; k++) begin
         rst(mk(2'h0, 3'h1, 5'(k)));
         sw(3'h7);
         rdc(css_pkg::CSS_OFS_CTRL, 32'h7001, 32'h7000);
         chk(osc.pll_multiplier, 32'(k - 4));
         chk(osc.pll_enable, 32'h1);
      end
      lock_ok <= 1'b1;
      repeat (4) @(posedge aclk);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h20, 32'h20);
      lock_ok <= 1'b0;
      repeat (4) @(posedge aclk);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h20, 32'h0);
      halt <= 1'b1;
      wait_trap();
      halt <= 1'b0;
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7009, 32'h1008);
      chk(osc.internal_low_power_rc_enable, 32'h1);
      done_en <= 1'b0;
      wr(css_pkg::CSS_OFS_CTRL, 32'h0201);
      wr(css_pkg::CSS_OFS_CTRL, 32'h0200);
      done_en <= 1'b1;
      repeat (10) @(posedge aclk);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7001, 32'h1000);
      for (int j = 0; j < 4; j++) begin
         sw(grps[j]);
         rdc(css_pkg::CSS_OFS_CTRL, 32'h7001, {17'h0, grps[j], 12'h0});
      end
      chk(osc.group_select, css_pkg::CSS_GRP_INTERNAL_LOW_POWER_RC);
      rst(mk(2'h0, 3'h3, 5'h04));
      slow_ok <= 1'b0;
      expired <= 1'b1;
      wait_trap();
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7000, 32'h1000);
      chk(osc.internal_low_power_rc_enable, 32'h1);
      sleep <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(osc.internal_low_power_rc_enable, 32'h0);
      rst(mk(2'h1, 3'h1, 5'h04));
      chk(osc.internal_low_power_rc_enable, 32'h1);
      expired <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(osc.internal_low_power_rc_enable, 32'h0);
      soft_wd <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(osc.internal_low_power_rc_enable, 32'h1);
      rdc(css_pkg::CSS_OFS_STAT, 32'h18, 32'h08);
      // The slow secondary group is only chosen here, with the monitor off.
      sw(3'h0);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7001, 32'h0000);
      rst(mk(2'h2, 3'h3, 5'h04));
      wr(css_pkg::CSS_OFS_CTRL, 32'h0101);
      repeat (10) @(posedge aclk);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h7000, 32'h3000);
      chk(osc.group_select, css_pkg::CSS_GRP_PRI);
      rdc(css_pkg::CSS_OFS_STAT, 32'h18, 32'h0);
      halt <= 1'b1;
      repeat (60) @(posedge aclk);
      rdc(css_pkg::CSS_OFS_CTRL, 32'h8, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
